/* File: core/brfp_map.vh */
/*
 brfp_map.vh: register indices, field positions, reset values, mode codes
 and timing counts of the buffered radio FIFO path.
 assumes: included by bare name from core design files and the testbench.
*/
`ifndef BRFP_MAP_VH
`define BRFP_MAP_VH

// register indices (byte-wide registers on the config select channel)
`define BRFP_REG_OPMODE     7'h00
`define BRFP_REG_DATAMODE   7'h01
`define BRFP_REG_SIZETHR    7'h05
`define BRFP_REG_IRQMAP     7'h0D
`define BRFP_REG_FIFOCTL    7'h0E
`define BRFP_REG_PATCFG     7'h12
`define BRFP_REG_PAT_FIRST  7'h16
`define BRFP_REG_PAT_LAST   7'h19

// spi command byte: read flag
`define BRFP_CMD_READ_BIT   7

// operating mode field
`define BRFP_MODE_HI        7
`define BRFP_MODE_LO        5
`define BRFP_MODE_STANDBY   3'h1
`define BRFP_MODE_SYNTH     3'h2
`define BRFP_MODE_RX        3'h3
`define BRFP_MODE_TX        3'h4
`define BRFP_FSET_BIT       0

// data mode config
`define BRFP_BUFSEL_BIT     5
`define BRFP_PKTEN_BIT      2

// pattern config length field
`define BRFP_PATLEN_HI      4
`define BRFP_PATLEN_LO      3

// fifo size / threshold
`define BRFP_SIZE_HI        7
`define BRFP_SIZE_LO        6
`define BRFP_THR_HI         5
`define BRFP_THR_LO         0

// interrupt pin mapping
`define BRFP_MAP0_HI        7
`define BRFP_MAP0_LO        6
`define BRFP_MAP1_HI        5
`define BRFP_MAP1_LO        4
`define BRFP_TXSEL_BIT      3

// fifo interrupt control
`define BRFP_FILLSRC_BIT    7
`define BRFP_FILL_BIT       6
`define BRFP_TXDONE_BIT     5
`define BRFP_STARTANY_BIT   4
`define BRFP_RSSIEN_BIT     3
`define BRFP_LOCKDIS_BIT    0

// reset values
`define BRFP_RST_OPMODE     8'h20
`define BRFP_RST_ZERO       8'h00

// bit period in system clocks
`define BRFP_BIT_DIV        100
`endif

/* File: core/brfp_fifo_path.v */
/*
 brfp_fifo_path.v: spi slave, byte fifo, transmit serializer, receive
 start-pattern detector, config registers and interrupt mapping of the
 buffered radio data path.
 assumes: the host is spi master (mode 0, msb first); modem bit inputs and
 rssi/lock status are on sys_clk; the bit rate is a divider on sys_clk.
*/
// Operation
// - fifo select low reaches fifo, config select low reaches registers; config wins
// - device is spi slave only; host drives every serial clock
// - fifo moves whole bytes; feeds modulator in tx, loads from rx stream
// - rx: first irq by selector: zero, write pulse, not-empty, pattern detect
// - tx: first irq always shows fifo not empty
// - rx: second irq by selector: zero, full, signal strength, threshold
// - tx: second irq shows full, or tx stop when select bit set
// - fill source 0 starts fill on pattern detect; 1 uses manual bit
// - manual fill bit starts/stops fill; in auto it shows detect, 1 rearms
// - tx done reads 0 while bits pending, 1 when all sent
// - start bit 0 starts tx when full; 1 when not empty
// - rssi enable gates rssi status; status is 1 at or above threshold
// - lock status 1 when unlocked; disable bit forces lock pin high
// - size field gives depth 16, 32, 48 or 64 bytes
// - threshold is field plus one; rx threshold irq when count reaches it
// - not-empty and full flags mark tx complete and rx message full
// - mode field: standby 001, synth 010, rx 011, tx 100
// - frequency set select bit picks first or second set
// - with fill source 0, preamble and pattern never enter rx fifo
// - buffered when packet enable 0 and buffered select 1
// - pattern length 8, 16, 24 or 32 bits
// - first pattern register msb matches earliest received bit
`timescale 1ns/1ps
`default_nettype none
`include "brfp_map.vh"

module brfp_fifo_path #(
    parameter BIT_DIV = `BRFP_BIT_DIV
) (
    // clock and reset
    input  wire       sys_clk,
    input  wire       nrst,
    // spi pins
    input  wire       spiSck,
    input  wire       spiMosi,
    output reg        spiMiso,
    output reg        spiMisoOe,
    input  wire       fifoSelectN,
    input  wire       configSelectN,
    // modem side
    output reg        txBit,
    output reg        txActive,
    input  wire       rxBit,
    input  wire       rssiAbove,
    input  wire       pllUnlocked,
    // control outputs
    output reg  [2:0] modeOut,
    output reg        freqSetSel,
    output reg        lockOut,
    output reg        firstInterruptOut,
    output reg        secondInterruptOut
);
    // pin synchronisers
    reg  [2:0]  sckS_r, mosiS_r, fselS_r, cselS_r;
    reg         sckF_r, fselF_r, cselF_r;
    wire        sckRise = (sckS_r[2] == sckS_r[1]) & sckS_r[2] & ~sckF_r;
    wire        sckFall = (sckS_r[2] == sckS_r[1]) & ~sckS_r[2] & sckF_r;
    wire        cfgSel  = ~cselF_r;
    wire        datSel  = ~fselF_r & cselF_r;
    wire        fselNxt = (fselS_r[2] == fselS_r[1]) ? fselS_r[2] : fselF_r;

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sckS_r  <= 3'h0;
            mosiS_r <= 3'h0;
            fselS_r <= 3'h7;
            cselS_r <= 3'h7;
            sckF_r  <= 1'b0;
            fselF_r <= 1'b1;
            cselF_r <= 1'b1;
        end else begin
            sckS_r  <= {sckS_r[1:0], spiSck};
            mosiS_r <= {mosiS_r[1:0], spiMosi};
            fselS_r <= {fselS_r[1:0], fifoSelectN};
            cselS_r <= {cselS_r[1:0], configSelectN};
            if (sckS_r[2] == sckS_r[1]) sckF_r <= sckS_r[2];
            fselF_r <= fselNxt;
            if (cselS_r[2] == cselS_r[1]) cselF_r <= cselS_r[2];
        end
    end

    // registers
    reg  [7:0]  opMode_r, dataMode_r, sizeThr_r, irqMap_r, fifoCtl_r;
    reg  [7:0]  patCfg_r;
    reg  [7:0]  patReg_r [0:3];
    reg  [7:0]  cmd_r;
    reg  [2:0]  spiBit_r;
    reg         byteIdx_r;
    reg  [7:0]  inSh_r, outSh_r;
    reg  [7:0]  regRd;

    wire [7:0]  rxByte   = {inSh_r[6:0], mosiS_r[2]};
    wire        byteDone = sckRise & (spiBit_r == 3'h7);
    wire [2:0]  mode     = opMode_r[`BRFP_MODE_HI:`BRFP_MODE_LO];
    wire        bufMode  = ~dataMode_r[`BRFP_PKTEN_BIT] &
                           dataMode_r[`BRFP_BUFSEL_BIT];
    wire        isTx     = bufMode & (mode == `BRFP_MODE_TX);
    wire        isRx     = bufMode & (mode == `BRFP_MODE_RX);
    wire        fillSrc  = fifoCtl_r[`BRFP_FILLSRC_BIT];
    wire        startAny = fifoCtl_r[`BRFP_STARTANY_BIT];
    wire        rssiEn   = fifoCtl_r[`BRFP_RSSIEN_BIT];
    wire        lockDis  = fifoCtl_r[`BRFP_LOCKDIS_BIT];
    wire        sigIrq   = rssiEn & rssiAbove;
    wire        regWr    = byteDone & cfgSel & byteIdx_r &
                           ~cmd_r[`BRFP_CMD_READ_BIT];
    wire [6:0]  wAddr    = cmd_r[6:0];

    // fifo storage and count
    reg  [7:0]  mem [0:63];
    reg  [5:0]  wrPtr_r, rdPtr_r;
    reg  [6:0]  count_r;
    wire [6:0]  depth    = {{1'b0, sizeThr_r[`BRFP_SIZE_HI:`BRFP_SIZE_LO]} +
                            3'h1, 4'h0};
    wire [6:0]  thresh   = {1'b0, sizeThr_r[`BRFP_THR_HI:`BRFP_THR_LO]} +
                           7'h01;
    wire        notEmpty = (count_r != 7'h00);
    wire        full     = (count_r >= depth);
    wire        thrIrq   = (count_r >= thresh);

    // tx and rx state
    reg  [2:0]  txCnt_r, rxCnt_r;
    reg  [7:0]  txSh_r, rxSh_r;
    reg         txRun_r, txBusy_r, txStop_r;
    reg  [31:0] patSh_r;
    reg         patDet_r, manFill_r;
    reg  [31:0] patWord, patMask;
    reg  [15:0] div_r;
    wire        bitEn    = (div_r == 16'h0000);
    wire        fillOn   = fillSrc ? manFill_r : patDet_r;
    wire        txDone   = ~notEmpty & ~txBusy_r;
    wire        rxPush   = isRx & bitEn & fillOn & (rxCnt_r == 3'h7) & ~full;
    wire [31:0] patNxt   = {patSh_r[30:0], rxBit};
    wire        patHit   = ((patNxt ^ patWord) & patMask) == 32'h00000000;
    wire        txPop    = isTx & txRun_r & bitEn & (txCnt_r == 3'h0) &
                           notEmpty;
    wire        spiPush  = byteDone & datSel & ~isRx & ~full;
    wire        spiPop   = byteDone & datSel & isRx & notEmpty;
    wire        push     = spiPush | rxPush;
    wire        pop      = spiPop | txPop;
    wire [7:0]  pushData = rxPush ? {rxSh_r[6:0], rxBit} : rxByte;
    // wrap by compare, since 48 is no power of two
    wire [5:0]  lastIdx  = depth[5:0] - 6'h01;
    wire [5:0]  wrNext   = (wrPtr_r == lastIdx) ? 6'h00 : wrPtr_r + 6'h01;
    wire [5:0]  rdNext   = (rdPtr_r == lastIdx) ? 6'h00 : rdPtr_r + 6'h01;

    // pattern aligned to the newest received bits
    always @* begin
        case (patCfg_r[`BRFP_PATLEN_HI:`BRFP_PATLEN_LO])
            2'h0: begin
                patWord = {24'h000000, patReg_r[0]};
                patMask = 32'h000000FF;
            end
            2'h1: begin
                patWord = {16'h0000, patReg_r[0], patReg_r[1]};
                patMask = 32'h0000FFFF;
            end
            2'h2: begin
                patWord = {8'h00, patReg_r[0], patReg_r[1], patReg_r[2]};
                patMask = 32'h00FFFFFF;
            end
            default: begin
                patWord = {patReg_r[0], patReg_r[1], patReg_r[2],
                           patReg_r[3]};
                patMask = 32'hFFFFFFFF;
            end
        endcase
    end

    // register read decode
    always @* begin
        regRd = 8'h00;
        if (wAddr == `BRFP_REG_OPMODE) begin
            regRd = opMode_r;
        end else if (wAddr == `BRFP_REG_DATAMODE) begin
            regRd = dataMode_r;
        end else if (wAddr == `BRFP_REG_SIZETHR) begin
            regRd = sizeThr_r;
        end else if (wAddr == `BRFP_REG_IRQMAP) begin
            regRd = irqMap_r;
        end else if (wAddr == `BRFP_REG_FIFOCTL) begin
            regRd = {fillSrc, fillOn, txDone, startAny, rssiEn, sigIrq,
                     pllUnlocked, lockDis};
        end else if (wAddr == `BRFP_REG_PATCFG) begin
            regRd = patCfg_r;
        end else if (wAddr >= `BRFP_REG_PAT_FIRST &&
                     wAddr <= `BRFP_REG_PAT_LAST) begin
            regRd = patReg_r[wAddr[1:0] - 2'h2];
        end
    end

    // spi shifter; in config and rx fifo reads the fall ending a byte loads the next msb, not a shift
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            spiBit_r  <= 3'h0;
            byteIdx_r <= 1'b0;
            inSh_r    <= 8'h00;
            outSh_r   <= 8'h00;
            cmd_r     <= 8'h00;
        end else if (!cfgSel && !datSel) begin
            spiBit_r  <= 3'h0;
            byteIdx_r <= 1'b0;
            outSh_r   <= fselNxt ? 8'h00 : mem[rdPtr_r];
        end else begin
            if (sckFall && spiBit_r == 3'h0 && cfgSel) begin
                outSh_r <= regRd;
            end else if (sckFall && spiBit_r == 3'h0 && isRx) begin
                outSh_r <= mem[rdPtr_r];
            end else if (sckFall) begin
                outSh_r <= {outSh_r[6:0], 1'b0};
            end
            if (sckRise) begin
                inSh_r   <= rxByte;
                spiBit_r <= spiBit_r + 3'h1;
            end
            if (byteDone && cfgSel) begin
                byteIdx_r <= 1'b1;
                if (!byteIdx_r) cmd_r <= rxByte;
            end
        end
    end

    // config registers; pattern detect set wins over a rearm write
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            opMode_r    <= `BRFP_RST_OPMODE;
            dataMode_r  <= `BRFP_RST_ZERO;
            sizeThr_r   <= `BRFP_RST_ZERO;
            irqMap_r    <= `BRFP_RST_ZERO;
            fifoCtl_r   <= `BRFP_RST_ZERO;
            patCfg_r    <= `BRFP_RST_ZERO;
            patReg_r[0] <= `BRFP_RST_ZERO;
            patReg_r[1] <= `BRFP_RST_ZERO;
            patReg_r[2] <= `BRFP_RST_ZERO;
            patReg_r[3] <= `BRFP_RST_ZERO;
            manFill_r   <= 1'b0;
            patDet_r    <= 1'b0;
        end else begin
            if (regWr) begin
                if (wAddr == `BRFP_REG_OPMODE) begin
                    opMode_r <= rxByte;
                end else if (wAddr == `BRFP_REG_DATAMODE) begin
                    dataMode_r <= rxByte;
                end else if (wAddr == `BRFP_REG_SIZETHR) begin
                    sizeThr_r <= rxByte;
                end else if (wAddr == `BRFP_REG_IRQMAP) begin
                    irqMap_r <= rxByte;
                end else if (wAddr == `BRFP_REG_FIFOCTL) begin
                    fifoCtl_r <= rxByte & 8'h99;
                    manFill_r <= rxByte[`BRFP_FILL_BIT];
                end else if (wAddr == `BRFP_REG_PATCFG) begin
                    patCfg_r <= rxByte;
                end else if (wAddr >= `BRFP_REG_PAT_FIRST &&
                             wAddr <= `BRFP_REG_PAT_LAST) begin
                    patReg_r[wAddr[1:0] - 2'h2] <= rxByte;
                end
            end
            if (isRx && bitEn && !patDet_r && patHit) begin
                patDet_r <= 1'b1;
            end else if (regWr && wAddr == `BRFP_REG_FIFOCTL &&
                         rxByte[`BRFP_FILL_BIT]) begin
                patDet_r <= 1'b0;
            end
        end
    end

    // fifo pointers and count
    always @(posedge sys_clk) begin
        if (push) mem[wrPtr_r] <= pushData;
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wrPtr_r <= 6'h00;
            rdPtr_r <= 6'h00;
            count_r <= 7'h00;
        end else begin
            if (push) wrPtr_r <= wrNext;
            if (pop) rdPtr_r <= rdNext;
            if (push && !pop) count_r <= count_r + 7'h01;
            else if (pop && !push) count_r <= count_r - 7'h01;
        end
    end

    // bit-rate divider, tx serializer, rx byte assembly
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            div_r    <= 16'h0000;
            txCnt_r  <= 3'h0;
            txSh_r   <= 8'h00;
            txRun_r  <= 1'b0;
            txBusy_r <= 1'b0;
            txStop_r <= 1'b0;
            txBit    <= 1'b0;
            rxCnt_r  <= 3'h0;
            rxSh_r   <= 8'h00;
            patSh_r  <= 32'h00000000;
        end else begin
            div_r <= bitEn ? BIT_DIV[15:0] - 16'h0001 : div_r - 16'h0001;
            if (!isTx) begin
                txRun_r  <= 1'b0;
                txBusy_r <= 1'b0;
                txStop_r <= 1'b0;
                txCnt_r  <= 3'h0;
            end else begin
                if (!txRun_r && (startAny ? notEmpty : full))
                    txRun_r <= 1'b1;
                if (txRun_r && bitEn) begin
                    if (txCnt_r == 3'h0) begin
                        if (notEmpty) begin
                            txBit    <= mem[rdPtr_r][7];
                            txSh_r   <= {mem[rdPtr_r][6:0], 1'b0};
                            txCnt_r  <= 3'h7;
                            txBusy_r <= 1'b1;
                            txStop_r <= 1'b0;
                        end else begin
                            txBusy_r <= 1'b0;
                            txRun_r  <= 1'b0;
                        end
                    end else begin
                        txBit   <= txSh_r[7];
                        txSh_r  <= {txSh_r[6:0], 1'b0};
                        txCnt_r <= txCnt_r - 3'h1;
                        if (txCnt_r == 3'h1 && !notEmpty)
                            txStop_r <= 1'b1;
                    end
                end
            end
            if (isRx && bitEn) begin
                patSh_r <= patNxt;
                if (fillOn) begin
                    rxSh_r  <= {rxSh_r[6:0], rxBit};
                    rxCnt_r <= rxCnt_r + 3'h1;
                end else begin
                    rxCnt_r <= 3'h0;
                end
            end else if (!isRx) begin
                rxCnt_r <= 3'h0;
            end
        end
    end

    // interrupt mapping and pin outputs
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            firstInterruptOut  <= 1'b0;
            secondInterruptOut <= 1'b0;
            spiMiso            <= 1'b0;
            spiMisoOe          <= 1'b0;
            txActive           <= 1'b0;
            modeOut            <= `BRFP_MODE_STANDBY;
            freqSetSel         <= 1'b0;
            lockOut            <= 1'b1;
        end else begin
            if (isTx) begin
                firstInterruptOut  <= notEmpty;
                secondInterruptOut <= irqMap_r[`BRFP_TXSEL_BIT] ?
                                      txStop_r : full;
            end else if (isRx) begin
                case (irqMap_r[`BRFP_MAP0_HI:`BRFP_MAP0_LO])
                    2'h0: firstInterruptOut <= 1'b0;
                    2'h1: firstInterruptOut <= rxPush;
                    2'h2: firstInterruptOut <= notEmpty;
                    default: firstInterruptOut <= patDet_r;
                endcase
                case (irqMap_r[`BRFP_MAP1_HI:`BRFP_MAP1_LO])
                    2'h0: secondInterruptOut <= 1'b0;
                    2'h1: secondInterruptOut <= full;
                    2'h2: secondInterruptOut <= sigIrq;
                    default: secondInterruptOut <= thrIrq;
                endcase
            end else begin
                firstInterruptOut  <= 1'b0;
                secondInterruptOut <= 1'b0;
            end
            spiMiso    <= outSh_r[7];
            spiMisoOe  <= cfgSel | datSel;
            txActive   <= txBusy_r;
            modeOut    <= mode;
            freqSetSel <= opMode_r[`BRFP_FSET_BIT];
            lockOut    <= lockDis | ~pllUnlocked;
        end
    end
endmodule // brfp_fifo_path
`default_nettype wire

/* File: testbench/brfp_fifo_path_assertions.sv */
/* port assertions for brfp_fifo_path.
   assumes: bound onto every instance, BIT_DIV handed on. */
`timescale 1ns/1ps
`default_nettype none
module brfp_checker #(parameter BIT_DIV = 100) (
    // clock and reset
    input wire logic       sys_clk, nrst,
    // spi pins
    input wire logic       spiSck, spiMiso, spiMisoOe,
    input wire logic       fifoSelectN, configSelectN,
    // modem and status
    input wire logic       txBit, txActive, pllUnlocked, lockOut,
    input wire logic [2:0] modeOut,
    input wire logic       firstInterruptOut, secondInterruptOut
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // cycles since txBit last moved
    logic [15:0] gapCnt_r;
    logic        txPrev_r;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            gapCnt_r <= 16'h0000;
            txPrev_r <= 1'b0;
        end else begin
            gapCnt_r <= (txBit != txPrev_r) ? 16'h0000 : gapCnt_r + 16'h0001;
            txPrev_r <= txBit;
        end
    end
    a_reset_values: assert property (
        $rose(nrst) |-> modeOut == 3'h1 && lockOut && !txActive)
        else $error("outputs wrong after reset");
    a_oe_idle: assert property (
        (fifoSelectN && configSelectN) [*6] |-> !spiMisoOe)
        else $error("miso driven while deselected");
    a_oe_active: assert property (
        (!fifoSelectN || !configSelectN) [*6] |-> spiMisoOe)
        else $error("miso not driven while selected");
    a_miso_sck_low: assert property (
        $changed(spiMiso) && spiMisoOe |-> !spiSck)
        else $error("miso moved while sck high");
    a_lock_pin: assert property (
        (!pllUnlocked) [*3] |-> lockOut)
        else $error("lock pin low while locked");
    a_irq_idle: assert property (
        (modeOut != 3'h3 && modeOut != 3'h4) [*3]
        |-> !firstInterruptOut && !secondInterruptOut)
        else $error("irq high outside rx or tx");
    a_tx_start_mode: assert property (
        $rose(txActive) |-> $past(modeOut) == 3'h4)
        else $error("transmit began outside tx mode");
    a_tx_bit_gap: assert property (
        txActive && $past(txActive) && txBit != txPrev_r
        |-> gapCnt_r >= BIT_DIV - 1)
        else $error("tx bit shorter than a bit period");
    c_tx: cover property ($rose(txActive));
    c_rx_pulse: cover property ($rose(firstInterruptOut) && modeOut == 3'h3);
    c_tx_stop: cover property ($rose(secondInterruptOut) && modeOut == 3'h4);
endmodule // brfp_checker
bind brfp_fifo_path brfp_checker #(.BIT_DIV(BIT_DIV)) u_chk (
    .sys_clk(sys_clk), .nrst(nrst), .spiSck(spiSck), .spiMiso(spiMiso),
    .spiMisoOe(spiMisoOe), .fifoSelectN(fifoSelectN),
    .configSelectN(configSelectN), .txBit(txBit), .txActive(txActive),
    .pllUnlocked(pllUnlocked), .lockOut(lockOut), .modeOut(modeOut),
    .firstInterruptOut(firstInterruptOut),
    .secondInterruptOut(secondInterruptOut));
`default_nettype wire

/* File: testbench/brfp_host_model.sv */
/* spi master standing in for the host.
   assumes: mode 0, msb first, sck stands low between frames. */
`timescale 1ns/1ps
`default_nettype none
module brfp_host_model (
    // spi master pins
    output var logic       spiSck, spiMosi, fifoSelectN, configSelectN,
    input  wire logic      spiMiso,
    // byte read back
    output var logic       rdStb,
    output var logic [7:0] rdByte
);
    logic [7:0] sh;
    initial begin
        {spiSck, spiMosi, fifoSelectN, configSelectN} = 4'h7;
        {rdStb, rdByte} = 9'h000;
    end
    // nb bytes of tx msb first; byte number pub is reported
    task automatic frame(input logic cfg, input logic [15:0] tx,
                         input int nb, input int pub);
        if (cfg) configSelectN = 1'b0;
        else fifoSelectN = 1'b0;
        #62.5;
        for (int i = 0; i < 8 * nb; i++) begin
            spiMosi = tx[15 - i];
            #62.5 spiSck = 1'b1;
            sh = {sh[6:0], spiMiso};
            #62.5 spiSck = 1'b0;
            if (i == 8 * pub - 1) begin
                rdByte = sh;
                rdStb = 1'b1;
                #1 rdStb = 1'b0;
            end
        end
        spiMosi = ~spiMosi;
        #62.5 {fifoSelectN, configSelectN} = 2'h3;
        #100;
    endtask
endmodule // brfp_host_model
`default_nettype wire

/* File: testbench/testbench.sv */
/* self-checking bench for brfp_fifo_path.
   assumes: brfp_host_model as master, brfp_checker bound. */
`timescale 1ns/1ps
`default_nettype none
`include "brfp_map.vh"
module testbench;
    logic        sys_clk, nrst, spiSck, spiMosi, spiMiso, spiMisoOe;
    logic        fifoSelectN, configSelectN, txBit, txActive, rxBit;
    logic        rssiAbove, pllUnlocked, freqSetSel, lockOut, rdStb;
    logic        firstInterruptOut, secondInterruptOut;
    logic [2:0]  modeOut;
    logic [7:0]  rdByte, d;
    logic [15:0] note;
    logic [15:0] rdQ [$];
    logic [7:0]  txQ [$];
    int n_errors = 0, tests_run = 0, seed = 55744, pulses = 0, p0;
    brfp_fifo_path #(.BIT_DIV(8)) dut (
        .sys_clk(sys_clk), .nrst(nrst), .spiSck(spiSck), .spiMosi(spiMosi),
        .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .fifoSelectN(fifoSelectN),
        .configSelectN(configSelectN), .txBit(txBit), .txActive(txActive),
        .rxBit(rxBit), .rssiAbove(rssiAbove), .pllUnlocked(pllUnlocked),
        .modeOut(modeOut), .freqSetSel(freqSetSel), .lockOut(lockOut),
        .firstInterruptOut(firstInterruptOut),
        .secondInterruptOut(secondInterruptOut));
    brfp_host_model host (
        .spiSck(spiSck), .spiMosi(spiMosi), .fifoSelectN(fifoSelectN),
        .configSelectN(configSelectN), .spiMiso(spiMiso), .rdStb(rdStb),
        .rdByte(rdByte));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp,
                              input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d compares %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [6:0] idx, input logic [7:0] v);
        tick;
        host.frame(1'b1, {1'b0, idx, v}, 2, 0);
    endtask
    // mask m picks the bits that are compared
    task automatic rd(input logic [6:0] idx, input logic [7:0] m,
                      input logic [7:0] e);
        rdQ.push_back({m, e});
        tick;
        host.frame(1'b1, {1'b1, idx, 8'h00}, 2, 2);
    endtask
    task automatic fifo(input logic [7:0] v, input int pub);
        tick;
        host.frame(1'b0, {v, 8'h00}, 1, pub);
    endtask
    // bits held 8 clocks, so each one meets exactly one bit enable
    task automatic rx_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            rxBit = b[i];
            repeat (8) @(posedge sys_clk);
            #1;
        end
    endtask
    task automatic wait_done;
        for (int i = 0; i < 3000 && (txQ.size() > 0 || txActive !== 1'b0);
             i++) @(posedge sys_clk);
        if (txQ.size() > 0 || txActive !== 1'b0) begin
            n_errors++;
            wrap_up;
        end
    endtask
    always @(posedge rdStb) begin
        note = rdQ.size() ? rdQ.pop_front() : 16'hFFXX;
        check_byte(rdByte & note[15:8], note[7:0], "read");
    end
    always @(negedge sys_clk) if (firstInterruptOut === 1'b1) pulses++;
    initial begin : txMon
        logic [7:0] sh;
        forever begin
            @(posedge txActive);
            repeat (4) @(negedge sys_clk);
            while (txActive === 1'b1) begin
                for (int i = 0; i < 8; i++) begin
                    sh = {sh[6:0], txBit};
                    repeat (8) @(negedge sys_clk);
                end
                check_byte(sh, txQ.size() ? txQ.pop_front() : 8'hXX,
                           "tx byte");
            end
        end
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_errors++;
        wrap_up;
    end
    initial begin
        {nrst, rxBit, rssiAbove, pllUnlocked} = 4'h1;
        repeat (3) @(posedge sys_clk);
        #1 nrst = 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(`BRFP_REG_OPMODE, 8'hFF, `BRFP_RST_OPMODE);
        rd(`BRFP_REG_IRQMAP, 8'hFF, 8'h00);
        rd(7'h7F, 8'hFF, 8'h00);
        for (int m = 1; m <= 4; m++) begin
            wr(`BRFP_REG_OPMODE, {m[2:0], 4'h0, m[0]});
            check_byte({5'h00, modeOut}, {5'h00, m[2:0]}, "mode");
            check_byte({7'h00, freqSetSel}, {7'h00, m[0]}, "fset");
        end
        check_byte({7'h00, lockOut}, 8'h00, "lock");
        rssiAbove = 1'b1;
        wr(`BRFP_REG_FIFOCTL, 8'h09);
        check_byte({7'h00, lockOut}, 8'h01, "lock off");
        rd(`BRFP_REG_FIFOCTL, 8'h0F, 8'h0F);
        tick;
        {pllUnlocked, rssiAbove} = 2'($random(seed)) & 2'h1;
        wr(`BRFP_REG_DATAMODE, 8'h20);
        wr(`BRFP_REG_SIZETHR, 8'h00);
        wr(`BRFP_REG_FIFOCTL, 8'h00);
        wr(`BRFP_REG_IRQMAP, 8'h00);
        wr(`BRFP_REG_OPMODE, 8'h40);
        check_byte({7'h00, lockOut}, 8'h01, "lock");
        wr(`BRFP_REG_OPMODE, 8'h80);
        for (int i = 0; i < 16; i++) begin
            check_byte({6'h00, txActive, firstInterruptOut}, {7'h00, i > 0},
                       "tx wait");
            d = 8'($random(seed));
            txQ.push_back(d);
            fifo(d, 0);
        end
        wait_done;
        check_byte({6'h00, firstInterruptOut, secondInterruptOut}, 8'h00,
                   "tx irq");
        rd(`BRFP_REG_FIFOCTL, 8'h20, 8'h20);
        wr(`BRFP_REG_IRQMAP, 8'h08);
        wr(`BRFP_REG_FIFOCTL, 8'h10);
        d = 8'($random(seed));
        txQ.push_back(d);
        fifo(d, 0);
        wait_done;
        check_byte({6'h00, firstInterruptOut, secondInterruptOut}, 8'h01,
                   "tx stop");
        repeat (8) @(posedge sys_clk);
        wr(`BRFP_REG_OPMODE, 8'h20);
        wr(`BRFP_REG_FIFOCTL, 8'h40);
        wr(`BRFP_REG_PATCFG, 8'h00);
        wr(`BRFP_REG_PAT_FIRST, 8'hB4);
        wr(`BRFP_REG_IRQMAP, 8'h70);
        wr(`BRFP_REG_SIZETHR, 8'h01);
        wr(`BRFP_REG_OPMODE, 8'h40);
        wr(`BRFP_REG_OPMODE, 8'h60);
        p0 = pulses;
        tick;
        rx_byte(8'h55);
        rx_byte(8'hB4);
        for (int i = 0; i < 3; i++) begin
            d = 8'($random(seed));
            rdQ.push_back({8'hFF, d});
            fork
                rx_byte(d);
                begin
                    repeat (20) @(posedge sys_clk);
                    check_byte({7'h00, secondInterruptOut}, {7'h00, i > 1},
                               "thr");
                    check_byte(8'(pulses - p0), 8'(i), "pulses");
                end
            join
        end
        for (int i = 0; i < 3; i++) fifo(8'h00, 1);
        tick;
        nrst = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 nrst = 1'b1;
        check_byte({5'h00, modeOut}, 8'h01, "reset");
        check_byte(8'(rdQ.size()), 8'h00, "reads");
        wrap_up;
    end
endmodule // testbench
`default_nettype wire
